// >>> common/lmr_pkg.sv
// package of opcode patterns, widths and carriers for the literal/move/return decoder
// Overview of operation
// RL1: the load-literal opcode puts the low instruction byte into the accumulator in one cycle, flags untouched.
// RL2: tools encode the two don't-care bits of load-literal as zero, but the decoder accepts any value there.
// RL3: the store-accumulator opcode writes the accumulator to the file register named by the 7-bit field in one cycle.
// RL4: the interrupt-return opcode pops the stack, loads the popped top entry into the pc, sets the global enable, in two cycles.
// RL5: the legacy configuration-load opcode copies the accumulator into the timer/prescaler register in one cycle.
// RL6: the timer/prescaler register is also read and written as an ordinary file register.
// RL7: the idle opcode ignores its two don't-care bits and only advances the pc for one cycle.
package lmr_pkg;
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 13;

   // opcode match: (insn & mask) == value, or insn == value for IRET_VAL and CFG_VAL
   localparam logic [13:0] LIT_MASK = 14'h3c00;
   localparam logic [13:0] LIT_VAL = 14'h3000;
   localparam logic [13:0] STORE_MASK = 14'h3f80;
   localparam logic [13:0] STORE_VAL = 14'h0080;
   localparam logic [13:0] IDLE_MASK = 14'h3f9f;
   localparam logic [13:0] IDLE_VAL = 14'h0000;
   localparam logic [13:0] IRET_VAL = 14'h0009;
   localparam logic [13:0] CFG_VAL = 14'h0062;

   // file-register address of the timer/prescaler register (arbitrary default)
   localparam logic [6:0] CFG_FADDR_DEF = 7'h01;
   localparam logic [7:0] CFG_RESET = 8'hff;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] FREAD_RESET = 8'h00;
   localparam logic [12:0] PC_RESET = 13'h0000;

   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } lmr_fwrite_t;

   typedef struct packed {
      logic        pop;
      logic        load;
      logic [12:0] pc;
   } lmr_pcctl_t;
endpackage : lmr_pkg

// >>> hw/lmr_decoder.sv
// decode/execute for load-literal, store, idle, interrupt return and legacy config load
module lmr_decoder
   import lmr_pkg::*;
#(
   parameter logic [6:0] CFG_FADDR = CFG_FADDR_DEF
) (
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_insn_valid,
   input  wire logic [13:0]       i_insn,
   input  wire logic [12:0]       i_stack_top_entry,
   input  wire lmr_fwrite_t       i_fwrite,
   input  wire logic [6:0]        i_fread_addr,
   output logic [7:0]             o_acc,
   output logic [7:0]             o_cfg,
   output logic [7:0]             o_fread_data,
   output logic                   o_fread_hit,
   output lmr_fwrite_t            o_fwrite,
   output lmr_pcctl_t             o_pcctl,
   output logic                   o_pc_advance,
   output logic                   o_global_irq_enable_set,
   output logic                   o_busy
);
   typedef enum logic [0:0] {LMR_EXEC, LMR_IRET2} lmr_state_t;

   lmr_state_t  state;
   lmr_state_t  next_state;
   logic        take;
   logic        match_lit;
   logic        match_store;
   logic        match_idle;
   logic        match_iret;
   logic        match_cfg;
   logic        is_lit;
   logic        is_store;
   logic        is_idle;
   logic        is_iret;
   logic        is_cfg;
   logic        store_to_cfg;
   logic        file_to_cfg;
   logic        fread_sel;
   logic        fwrite_en;
   logic [6:0]  fwrite_addr;
   logic [7:0]  fwrite_data;
   logic        pc_pop;
   logic        pc_load;
   logic [12:0] pc_value;

   // the port widths are fixed by the opcode format, so the package has to agree
   if (INSN_W != 14) begin : g_bad_insn_w
      $error("lmr_decoder: instruction width must be 14");
   end
   if (DATA_W != 8) begin : g_bad_data_w
      $error("lmr_decoder: data width must be 8");
   end
   if (FADDR_W != 7) begin : g_bad_faddr_w
      $error("lmr_decoder: file address width must be 7");
   end
   if (PC_W != 13) begin : g_bad_pc_w
      $error("lmr_decoder: program counter width must be 13");
   end
   // address 0 is the indirect slot and never a real register
   if (CFG_FADDR == 7'h00) begin : g_bad_cfg_faddr
      $error("lmr_decoder: CFG_FADDR 0 is the indirect slot");
   end

   // a word offered in the return's second cycle is dropped, so the host must hold it
   assign take = i_insn_valid && (state == LMR_EXEC);

   // the five patterns are disjoint, so at most one match is ever true
   assign match_lit   = ((i_insn & LIT_MASK) == LIT_VAL); // RL2
   assign match_store = ((i_insn & STORE_MASK) == STORE_VAL);
   assign match_idle  = ((i_insn & IDLE_MASK) == IDLE_VAL); // RL7
   assign match_iret  = (i_insn == IRET_VAL);
   assign match_cfg   = (i_insn == CFG_VAL);

   assign is_lit   = take && match_lit;
   assign is_store = take && match_store;
   assign is_idle  = take && match_idle;
   assign is_iret  = take && match_iret;
   assign is_cfg   = take && match_cfg;

   assign store_to_cfg = is_store && (i_insn[6:0] == CFG_FADDR); // RL6
   assign file_to_cfg  = i_fwrite.en && (i_fwrite.addr == CFG_FADDR); // RL6
   assign fread_sel    = (i_fread_addr == CFG_FADDR);

   always_comb begin
      next_state = state;
      case (state)
         LMR_EXEC: begin
            if (is_iret) begin
               next_state = LMR_IRET2; // RL4
            end
         end
         LMR_IRET2: begin
            next_state = LMR_EXEC;
         end
         default: begin
            next_state = LMR_EXEC;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= LMR_EXEC;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_acc <= ACC_RESET;
      end else if (is_lit) begin
         o_acc <= i_insn[7:0]; // RL1
      end
   end

   // the legacy load and a store never coincide, but an outside write can; the
   // instruction then wins and the outside write is lost
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cfg <= CFG_RESET;
      end else if (is_cfg) begin
         o_cfg <= o_acc; // RL5
      end else if (store_to_cfg) begin
         o_cfg <= o_acc; // RL6
      end else if (file_to_cfg) begin
         o_cfg <= i_fwrite.data; // RL6
      end
   end

   // the read port answers one cycle after the address, like any file register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_fread_hit <= 1'b0;
      end else begin
         o_fread_hit <= fread_sel; // RL6
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_fread_data <= FREAD_RESET;
      end else begin
         o_fread_data <= fread_sel ? o_cfg : FREAD_RESET;
      end
   end

   // a store names its target from the low seven opcode bits and carries the accumulator
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fwrite_en <= 1'b0;
      end else begin
         fwrite_en <= is_store; // RL3
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fwrite_addr <= '0;
      end else begin
         fwrite_addr <= i_insn[6:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fwrite_data <= '0;
      end else begin
         fwrite_data <= o_acc;
      end
   end

   assign o_fwrite = '{en: fwrite_en, addr: fwrite_addr, data: fwrite_data};

   // the stack top is taken on the pop edge, so the pc gets the entry being removed
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_pop <= 1'b0;
      end else begin
         pc_pop <= is_iret; // RL4
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_load <= 1'b0;
      end else begin
         pc_load <= is_iret; // RL4
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pc_value <= PC_RESET;
      end else begin
         pc_value <= i_stack_top_entry; // RL4
      end
   end

   assign o_pcctl = '{pop: pc_pop, load: pc_load, pc: pc_value};

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_global_irq_enable_set <= 1'b0;
      end else begin
         o_global_irq_enable_set <= is_iret; // RL4
      end
   end

   // every single-cycle opcode of this group steps the pc; the return loads it instead
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pc_advance <= 1'b0;
      end else begin
         o_pc_advance <= is_idle || is_lit || is_store || is_cfg; // RL7
      end
   end

   // busy marks the return's second cycle, in which no new word is taken
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= is_iret; // RL4
      end
   end
endmodule : lmr_decoder

// >>> test/lmr_decoder_asserts.sv
// port-level assertions for the literal/move/return decoder
module lmr_decoder_asserts
   import lmr_pkg::*;
#(parameter logic [6:0] CFG_FADDR = CFG_FADDR_DEF) (
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_insn_valid,
   input wire logic [13:0] i_insn,
   input wire logic [12:0] i_stack_top_entry,
   input wire lmr_fwrite_t i_fwrite,
   input wire logic [7:0]  o_acc,
   input wire logic [7:0]  o_cfg,
   input wire lmr_fwrite_t o_fwrite,
   input wire lmr_pcctl_t  o_pcctl,
   input wire logic        o_pc_advance,
   input wire logic        o_global_irq_enable_set,
   input wire logic        o_busy);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire logic go = i_insn_valid && !o_busy;
   a_lit_load: assert property (go && (i_insn & LIT_MASK) == LIT_VAL
      |=> o_acc == $past(i_insn[7:0])) else $error("literal not loaded");
   a_store_write: assert property (go && (i_insn & STORE_MASK) == STORE_VAL
      |=> o_fwrite == {1'b1, $past(i_insn[6:0]), $past(o_acc)}) else $error("bad store");
   a_iret_pop: assert property (go && i_insn == IRET_VAL
      |=> o_pcctl == {2'b11, $past(i_stack_top_entry)} && o_global_irq_enable_set && o_busy
      ##1 !o_busy) else $error("bad irq return");
   a_cfg_load: assert property (go && i_insn == CFG_VAL
      |=> o_cfg == $past(o_acc)) else $error("config not loaded");
   a_cfg_store: assert property (go && (i_insn & STORE_MASK) == STORE_VAL
      && i_insn[6:0] == CFG_FADDR |=> o_cfg == $past(o_acc)) else $error("config store lost");
   a_cfg_file: assert property (i_fwrite.en && i_fwrite.addr == CFG_FADDR && !go
      |=> o_cfg == $past(i_fwrite.data)) else $error("config file write lost");
   a_idle_keep: assert property (go && (i_insn & IDLE_MASK) == IDLE_VAL
      |=> o_pc_advance && !o_fwrite.en && $stable(o_acc)) else $error("idle changed state");
endmodule : lmr_decoder_asserts
bind lmr_decoder lmr_decoder_asserts #(.CFG_FADDR(CFG_FADDR)) u_chk (.*);

// >>> test/lmr_decoder_tb_top.sv
// self-checking bench for the literal/move/return decoder
module lmr_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lmr_pkg::*;
   logic i_clk = 0, i_nrst = 0, i_insn_valid = 0, o_fread_hit, o_pc_advance;
   logic o_global_irq_enable_set, o_busy;
   logic [13:0] i_insn = '0;
   logic [12:0] i_stack_top_entry = '0;
   logic [6:0]  i_fread_addr = '0;
   logic [7:0]  o_acc, o_cfg, o_fread_data;
   lmr_fwrite_t i_fwrite = '0, o_fwrite;
   lmr_pcctl_t  o_pcctl;
   int err_total = 0, checks_done = 0, cyc = 0;
   lmr_decoder #(.CFG_FADDR(7'h01)) lmr_decoder_i (.*);
   initial forever #20 i_clk = ~i_clk;
   task final_report;
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // one instruction, outputs sampled just after the answering edge
   task op(input logic [13:0] w);
      @(posedge i_clk) begin i_insn_valid <= 1; i_insn <= w; end
      @(posedge i_clk) i_insn_valid <= 0;
      #1;
   endtask : op
   task t_move;
      for (int d = 0; d < 4; d++) begin
         op(LIT_VAL | 14'(d << 8) | 14'(8'h5a + d)); chk(o_acc, 8'h5a + d);
      end
      op(STORE_VAL | 14'h7f); chk(o_fwrite, {1'b1, 7'h7f, 8'h5d});
      op(CFG_VAL); chk(o_cfg, 8'h5d);
      op(14'h0060); chk({o_pc_advance, o_fwrite.en, o_acc}, {2'b10, 8'h5d});
   endtask : t_move
   // the word offered while busy must be ignored
   task t_iret;
      @(posedge i_clk) begin i_insn_valid <= 1; i_insn <= IRET_VAL; i_stack_top_entry <= 13'h1abc; end
      @(posedge i_clk) i_insn <= 14'h3077;
      #1 chk({o_pcctl, o_global_irq_enable_set, o_busy}, {2'b11, 13'h1abc, 2'b11});
      @(posedge i_clk) i_insn_valid <= 0;
      #1 chk({o_busy, o_pcctl.pop, o_acc}, {2'b00, 8'h5d});
   endtask : t_iret
   task t_file;
      @(posedge i_clk) begin i_fwrite <= {1'b1, 7'h01, 8'h3c}; i_fread_addr <= 7'h01; end
      @(posedge i_clk) i_fwrite.en <= 0;
      @(posedge i_clk) #1 chk({o_cfg, o_fread_hit, o_fread_data}, {8'h3c, 1'b1, 8'h3c});
      @(posedge i_clk) i_fread_addr <= 7'h02;
      @(posedge i_clk) #1 chk({o_fread_hit, o_fread_data}, 9'h000);
      op(STORE_VAL | 14'h01); chk({o_cfg, o_fwrite}, {8'h5d, 1'b1, 7'h01, 8'h5d});
   endtask : t_file
   always @(posedge i_clk) if (++cyc == 2000) begin err_total++; final_report(); end
   initial begin
      repeat (5) @(posedge i_clk);
      i_nrst <= 1;
      #1 chk({o_acc, o_cfg}, {8'h00, 8'hff});
      t_move();
      t_iret();
      t_file();
      final_report();
   end
endmodule : lmr_decoder_tb_top
